//--- pcd_dly_if.sv
interface pcd_dly_if #(parameter int DW = 10);
  logic tick;
  logic din;
  logic [DW-1:0] count;
  logic dout;
  modport ctrl (output tick, output din, output count, input dout);
  modport dly (input tick, input din, input count, output dout);
endinterface : pcd_dly_if

//--- pcd_edge_delay.sv
module pcd_edge_delay #(
  parameter int DW = 10,
  parameter bit FALL = 1'b0
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  pcd_dly_if.dly port
);
  logic din_eff;
  logic r_q;
  logic [DW-1:0] cnt_q;

  // falling-edge delay is a rising-edge delay on the inverted path
  assign din_eff = FALL ? ~port.din : port.din;
  assign port.dout = FALL ? ~r_q : r_q;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r_q <= 1'b0;
      cnt_q <= '0;
    end else if (!din_eff) begin
      r_q <= 1'b0; // RULE11
      cnt_q <= '0;
    end else if (!r_q) begin
      if (cnt_q >= port.count) begin
        r_q <= 1'b1; // RULE11
      end else if (port.tick) begin
        cnt_q <= cnt_q + DW'(1);
      end
    end
  end

  property p_edge_held;
    @(posedge mclk_i) disable iff (!rstn_i)
    $rose(r_q) |-> ($past(cnt_q) >= $past(port.count)) && $past(din_eff);
  endproperty
  a_edge_held: assert property (p_edge_held) else $error("edge passed before delay count"); // RULE11

  property p_other_edge_fast;
    @(posedge mclk_i) disable iff (!rstn_i)
    !din_eff |=> !r_q;
  endproperty
  a_other_edge_fast: assert property (p_other_edge_fast) else $error("undelayed edge held back"); // RULE11
endmodule : pcd_edge_delay

//--- pcd_gate_model.sv
module pcd_gate_model (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic a_i,
  input wire logic b_i,
  input wire logic sync_i,
  output logic [15:0] a_high_o,
  output logic [15:0] a_per_o,
  output logic [15:0] b_high_o,
  output logic [15:0] sync_per_o,
  output logic [15:0] a_cyc_o,
  output logic [15:0] ovl_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic a_q, b_q, s_q;
  logic [15:0] ca_q, cb_q, cs_q;
  // widths and periods in modulator clocks, latched at each edge
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      s_q <= 1'b0;
      ca_q <= 16'h0000;
      cb_q <= 16'h0000;
      cs_q <= 16'h0000;
      a_high_o <= 16'h0000;
      a_per_o <= 16'h0000;
      b_high_o <= 16'h0000;
      sync_per_o <= 16'h0000;
      a_cyc_o <= 16'h0000;
      ovl_o <= 16'h0000;
    end else begin
      a_q <= a_i;
      b_q <= b_i;
      s_q <= sync_i;
      ca_q <= (a_i && !a_q) ? 16'h0001 : ca_q + 16'h0001;
      cb_q <= (b_i && !b_q) ? 16'h0001 : cb_q + 16'h0001;
      cs_q <= (sync_i && !s_q) ? 16'h0001 : cs_q + 16'h0001;
      if (a_i && !a_q) begin
        a_per_o <= ca_q;
        a_cyc_o <= a_cyc_o + 16'h0001;
      end
      if (!a_i && a_q) begin
        a_high_o <= ca_q;
      end
      if (!b_i && b_q) begin
        b_high_o <= cb_q;
      end
      if (sync_i && !s_q) begin
        sync_per_o <= cs_q;
      end
      // shoot-through cycles on the power stage
      if (a_i && b_i) begin
        ovl_o <= ovl_o + 16'h0001;
      end
    end
  end
endmodule : pcd_gate_model

//--- pcd_params.svh
`ifndef PCD_PARAMS_SVH
`define PCD_PARAMS_SVH

// register byte offsets
`define PCD_OFF_CTRL 6'h00
`define PCD_OFF_PERIOD 6'h04
`define PCD_OFF_COMPARE_VALUE_A 6'h08
`define PCD_OFF_COMPARE_VALUE_B 6'h0C
`define PCD_OFF_PHASE 6'h10
`define PCD_OFF_ACT_A 6'h14
`define PCD_OFF_ACT_B 6'h18
`define PCD_OFF_DB_CTRL 6'h1C
`define PCD_OFF_RISE_DLY 6'h20
`define PCD_OFF_FALL_DLY 6'h24
`define PCD_OFF_STATUS 6'h28

// control register fields
`define PCD_CTRL_RUN 0
`define PCD_CTRL_PHASE_EN 1
`define PCD_CTRL_SYNC_EN 2
`define PCD_CTRL_HSP_LSB 4
`define PCD_CTRL_BASE_LSB 8
`define PCD_CTRL_W 11

// dead-band control fields
`define PCD_DB_BYP_A 0
`define PCD_DB_BYP_B 1
`define PCD_DB_POL_RISE 2
`define PCD_DB_POL_FALL 3
`define PCD_DB_SRC_RISE 4
`define PCD_DB_SRC_FALL 5
`define PCD_DB_SWAP_A 6
`define PCD_DB_SWAP_B 7
`define PCD_DB_ROUTE 8
`define PCD_DB_W 9

// status fields above the counter value
`define PCD_STAT_DIR_DOWN 16
`define PCD_STAT_OUT_A 17
`define PCD_STAT_OUT_B 18

// reset values
`define PCD_RST_CTRL 11'h000
`define PCD_RST_DB 9'h000
`define PCD_RST_ACT 12'h000

// sync-in to counter load, in modulator clocks, counted from the source
`define PCD_SYNC_LAT 2

`endif

//--- pcd_pkg.sv
package pcd_pkg;
  typedef enum logic [1:0] {
    PCD_ACT_NONE = 2'h0,
    PCD_ACT_CLR = 2'h1,
    PCD_ACT_SET = 2'h2,
    PCD_ACT_TGL = 2'h3
  } pcd_act_e;

  typedef enum logic [1:0] {
    PCD_DIR_UP = 2'h1,
    PCD_DIR_DOWN = 2'h2
  } pcd_dir_e;

  typedef struct packed {
    pcd_act_e cbd;
    pcd_act_e cbu;
    pcd_act_e cad;
    pcd_act_e cau;
    pcd_act_e prd;
    pcd_act_e zro;
  } pcd_actcfg_s;

  function automatic logic pcd_apply(input logic cur, input logic ev, input pcd_act_e act);
    logic r;
    r = cur;
    if (ev) begin
      case (act)
        PCD_ACT_CLR: r = 1'b0;
        PCD_ACT_SET: r = 1'b1;
        PCD_ACT_TGL: r = ~cur;
        default: r = cur;
      endcase
    end
    return r;
  endfunction : pcd_apply
endpackage : pcd_pkg

//--- pcd_prescaler.sv
module pcd_prescaler #(
  parameter int PW = 11
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic clr_i,
  input wire logic [PW-1:0] div_i,
  output logic tick_o
);
  logic [PW-1:0] cnt_q;

  // one tick every div_i modulator clocks
  assign tick_o = (cnt_q >= div_i - PW'(1)); // RULE16

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= '0;
    end else if (clr_i || tick_o) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + PW'(1);
    end
  end

  // three quiet clocks at divide-by-four, then the next tick is due
  sequence s_quiet_div4;
    (!clr_i && div_i == PW'(4))[*3];
  endsequence

  property p_tick_spacing;
    @(posedge mclk_i) disable iff (!rstn_i)
    (tick_o && !clr_i && div_i == PW'(4)) ##1 s_quiet_div4 |=> tick_o;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("prescaler tick spacing wrong"); // RULE16
endmodule : pcd_prescaler

//--- pcd_pwm_pair.sv
// Function
// (RULE1) Compare counter every count with zero, period, compare A and B.
// (RULE2) Each match applies per-output action: clear, set, toggle or nothing.
// (RULE3) Up and down compare matches select separate actions.
// (RULE4) Up-down counter climbs zero to period and falls back.
// (RULE5) Set on up, clear on down gives high time twice period minus compare.
// (RULE6) Rise and fall delay paths each select A or B as source.
// (RULE7) Route selector places delays; only one output may carry both.
// (RULE8) Each delay path has a polarity inverter; fall set gives complement.
// (RULE9) Bypass selectors pick delayed or undelayed signal per output.
// (RULE10) Swap selectors pass or exchange the A and B results.
// (RULE11) Rising and falling edges delayed by programmed time-base counts.
// (RULE12) Complementary mode: A is source rise-delayed, B inverted fall-delayed.
// (RULE13) Sync pulse with phase loading enabled loads phase into counter.
// (RULE14) Sync reaches receiver two modulator clocks after source.
// (RULE15) Sync source emits sync pulse whenever counter equals zero.
// (RULE16) Time-base clock is modulator clock over two prescalers' product.
// (RULE17) Software must enable phase loading and set phase on receivers.
// (RULE18) Reset holds counter zero, clears delays, drives outputs low.
//
// Our own choices: the Avalon-MM slave port and the address map.
`include "pcd_params.svh"

module pcd_pwm_pair #(
  parameter int CW = 16,
  parameter int DW = 10
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic sync_input_pulse_i,
  output logic sync_output_pulse_o,
  output logic output_a_o,
  output logic output_b_o
);
  localparam int PW = 11;

  logic [`PCD_CTRL_W-1:0] ctrl_q;
  logic [CW-1:0] period_value_q;
  logic [CW-1:0] compare_value_a_q;
  logic [CW-1:0] compare_value_b_q;
  logic [CW-1:0] phase_value_q;
  pcd_pkg::pcd_actcfg_s act_a_q;
  pcd_pkg::pcd_actcfg_s act_b_q;
  logic [`PCD_DB_W-1:0] db_q;
  logic [DW-1:0] rise_delay_count_q;
  logic [DW-1:0] fall_delay_count_q;
  logic [31:0] rdata_q;
  logic ack_q;

  logic [CW-1:0] time_base_counter_q;
  pcd_pkg::pcd_dir_e dir_q;
  logic sync_in_q;
  logic sync_out_q;
  logic aq_a_q;
  logic aq_b_q;
  logic aq_a_d;
  logic aq_b_d;
  logic out_a_q;
  logic out_b_q;

  logic req;
  logic acc_wr;
  logic [31:0] cur_word;
  logic [31:0] merged;
  logic run;
  logic phase_en;
  logic load;
  logic tick;
  logic ev;
  logic ev_zro;
  logic ev_prd;
  logic ev_cau;
  logic ev_cad;
  logic ev_cbu;
  logic ev_cbd;
  logic [2:0] hsp_sel;
  logic [2:0] base_sel;
  logic [3:0] hsp_div;
  logic [7:0] base_div;
  logic [PW-1:0] tb_div;
  logic rise_pol;
  logic fall_pol;
  logic dly_a;
  logic dly_b;
  logic pre_a;
  logic pre_b;
  logic fin_a;
  logic fin_b;

  // Avalon-MM slave: one wait cycle, then the access completes
  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_q;
  assign acc_wr = avs_write_i & ack_q;
  assign avs_readdata_o = rdata_q;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  always_comb begin
    cur_word = 32'h0000_0000;
    if (avs_address_i == `PCD_OFF_CTRL) begin
      cur_word = 32'(ctrl_q);
    end else if (avs_address_i == `PCD_OFF_PERIOD) begin
      cur_word = 32'(period_value_q);
    end else if (avs_address_i == `PCD_OFF_COMPARE_VALUE_A) begin
      cur_word = 32'(compare_value_a_q);
    end else if (avs_address_i == `PCD_OFF_COMPARE_VALUE_B) begin
      cur_word = 32'(compare_value_b_q);
    end else if (avs_address_i == `PCD_OFF_PHASE) begin
      cur_word = 32'(phase_value_q);
    end else if (avs_address_i == `PCD_OFF_ACT_A) begin
      cur_word = 32'(act_a_q);
    end else if (avs_address_i == `PCD_OFF_ACT_B) begin
      cur_word = 32'(act_b_q);
    end else if (avs_address_i == `PCD_OFF_DB_CTRL) begin
      cur_word = 32'(db_q);
    end else if (avs_address_i == `PCD_OFF_RISE_DLY) begin
      cur_word = 32'(rise_delay_count_q);
    end else if (avs_address_i == `PCD_OFF_FALL_DLY) begin
      cur_word = 32'(fall_delay_count_q);
    end else if (avs_address_i == `PCD_OFF_STATUS) begin
      cur_word = 32'(time_base_counter_q);
      cur_word[`PCD_STAT_DIR_DOWN] = (dir_q == pcd_pkg::PCD_DIR_DOWN);
      cur_word[`PCD_STAT_OUT_A] = out_a_q;
      cur_word[`PCD_STAT_OUT_B] = out_b_q;
    end
  end

  generate
    for (genvar i = 0; i < 4; i++) begin : g_lane
      assign merged[8*i+:8] = avs_byteenable_i[i] ? avs_writedata_i[8*i+:8] : cur_word[8*i+:8];
    end
  endgenerate

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read_i && !ack_q) begin
      rdata_q <= cur_word;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_q <= `PCD_RST_CTRL;
      period_value_q <= '0;
      compare_value_a_q <= '0;
      compare_value_b_q <= '0;
      phase_value_q <= '0;
      act_a_q <= `PCD_RST_ACT;
      act_b_q <= `PCD_RST_ACT;
      db_q <= `PCD_RST_DB;
      rise_delay_count_q <= '0;
      fall_delay_count_q <= '0;
    end else if (acc_wr) begin
      if (avs_address_i == `PCD_OFF_CTRL) begin
        ctrl_q <= merged[`PCD_CTRL_W-1:0];
      end else if (avs_address_i == `PCD_OFF_PERIOD) begin
        period_value_q <= merged[CW-1:0];
      end else if (avs_address_i == `PCD_OFF_COMPARE_VALUE_A) begin
        compare_value_a_q <= merged[CW-1:0];
      end else if (avs_address_i == `PCD_OFF_COMPARE_VALUE_B) begin
        compare_value_b_q <= merged[CW-1:0];
      end else if (avs_address_i == `PCD_OFF_PHASE) begin
        phase_value_q <= merged[CW-1:0];
      end else if (avs_address_i == `PCD_OFF_ACT_A) begin
        act_a_q <= pcd_pkg::pcd_actcfg_s'(merged[11:0]);
      end else if (avs_address_i == `PCD_OFF_ACT_B) begin
        act_b_q <= pcd_pkg::pcd_actcfg_s'(merged[11:0]);
      end else if (avs_address_i == `PCD_OFF_DB_CTRL) begin
        db_q <= merged[`PCD_DB_W-1:0];
      end else if (avs_address_i == `PCD_OFF_RISE_DLY) begin
        rise_delay_count_q <= merged[DW-1:0];
      end else if (avs_address_i == `PCD_OFF_FALL_DLY) begin
        fall_delay_count_q <= merged[DW-1:0];
      end
    end
  end

  // time-base clock divider: high-speed 1,2,4..14 times base 1,2..128
  assign run = ctrl_q[`PCD_CTRL_RUN];
  assign phase_en = ctrl_q[`PCD_CTRL_PHASE_EN];
  assign hsp_sel = ctrl_q[`PCD_CTRL_HSP_LSB+:3];
  assign base_sel = ctrl_q[`PCD_CTRL_BASE_LSB+:3];
  assign hsp_div = (hsp_sel == 3'h0) ? 4'h1 : {hsp_sel, 1'b0};
  assign base_div = 8'h01 << base_sel;
  assign tb_div = PW'(hsp_div) * PW'(base_div); // RULE16

  pcd_prescaler #(.PW(PW)) u_presc (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .clr_i(load || !run),
    .div_i(tb_div),
    .tick_o(tick)
  );

  // sync input registered once: lands two clocks after the source's zero
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_in_q <= 1'b0;
    end else begin
      sync_in_q <= sync_input_pulse_i; // RULE14
    end
  end

  assign load = sync_in_q & phase_en; // RULE13 RULE17

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      time_base_counter_q <= '0; // RULE18
      dir_q <= pcd_pkg::PCD_DIR_UP;
    end else if (load) begin
      time_base_counter_q <= phase_value_q; // RULE13
    end else if (tick && run) begin
      case (dir_q)
        pcd_pkg::PCD_DIR_UP: begin
          if (time_base_counter_q >= period_value_q) begin
            dir_q <= pcd_pkg::PCD_DIR_DOWN; // RULE4
            time_base_counter_q <= (time_base_counter_q == '0) ? '0 : time_base_counter_q - CW'(1);
          end else begin
            time_base_counter_q <= time_base_counter_q + CW'(1);
          end
        end
        pcd_pkg::PCD_DIR_DOWN: begin
          if (time_base_counter_q == '0) begin
            dir_q <= pcd_pkg::PCD_DIR_UP; // RULE4
            time_base_counter_q <= (period_value_q == '0) ? '0 : CW'(1);
          end else begin
            time_base_counter_q <= time_base_counter_q - CW'(1);
          end
        end
        default: dir_q <= pcd_pkg::PCD_DIR_UP;
      endcase
    end
  end

  // match events, one per time-base count
  assign ev = tick & run & ~load;
  assign ev_zro = ev && (time_base_counter_q == '0); // RULE1
  assign ev_prd = ev && (time_base_counter_q == period_value_q); // RULE1
  assign ev_cau = ev && (time_base_counter_q == compare_value_a_q) && (dir_q == pcd_pkg::PCD_DIR_UP); // RULE1 RULE3
  assign ev_cad = ev && (time_base_counter_q == compare_value_a_q) && (dir_q == pcd_pkg::PCD_DIR_DOWN); // RULE1 RULE3
  assign ev_cbu = ev && (time_base_counter_q == compare_value_b_q) && (dir_q == pcd_pkg::PCD_DIR_UP); // RULE1 RULE3
  assign ev_cbd = ev && (time_base_counter_q == compare_value_b_q) && (dir_q == pcd_pkg::PCD_DIR_DOWN); // RULE1 RULE3

  // own compare events applied last so they win
  always_comb begin
    aq_a_d = aq_a_q;
    aq_a_d = pcd_pkg::pcd_apply(aq_a_d, ev_zro, act_a_q.zro); // RULE2
    aq_a_d = pcd_pkg::pcd_apply(aq_a_d, ev_prd, act_a_q.prd);
    aq_a_d = pcd_pkg::pcd_apply(aq_a_d, ev_cbu, act_a_q.cbu);
    aq_a_d = pcd_pkg::pcd_apply(aq_a_d, ev_cbd, act_a_q.cbd);
    aq_a_d = pcd_pkg::pcd_apply(aq_a_d, ev_cau, act_a_q.cau); // RULE3 RULE5
    aq_a_d = pcd_pkg::pcd_apply(aq_a_d, ev_cad, act_a_q.cad); // RULE3 RULE5
    aq_b_d = aq_b_q;
    aq_b_d = pcd_pkg::pcd_apply(aq_b_d, ev_zro, act_b_q.zro); // RULE2
    aq_b_d = pcd_pkg::pcd_apply(aq_b_d, ev_prd, act_b_q.prd);
    aq_b_d = pcd_pkg::pcd_apply(aq_b_d, ev_cau, act_b_q.cau);
    aq_b_d = pcd_pkg::pcd_apply(aq_b_d, ev_cad, act_b_q.cad);
    aq_b_d = pcd_pkg::pcd_apply(aq_b_d, ev_cbu, act_b_q.cbu); // RULE3 RULE5
    aq_b_d = pcd_pkg::pcd_apply(aq_b_d, ev_cbd, act_b_q.cbd); // RULE3 RULE5
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aq_a_q <= 1'b0; // RULE18
      aq_b_q <= 1'b0;
    end else begin
      aq_a_q <= aq_a_d;
      aq_b_q <= aq_b_d;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_out_q <= 1'b0;
    end else begin
      sync_out_q <= ev_zro & ctrl_q[`PCD_CTRL_SYNC_EN]; // RULE15
    end
  end
  assign sync_output_pulse_o = sync_out_q;

  // dead-band stage
  pcd_dly_if #(.DW(DW)) rise_if ();
  pcd_dly_if #(.DW(DW)) fall_if ();

  assign rise_if.tick = tick;
  assign fall_if.tick = tick;
  assign rise_if.count = rise_delay_count_q;
  assign fall_if.count = fall_delay_count_q;
  assign rise_if.din = db_q[`PCD_DB_SRC_RISE] ? aq_b_q : aq_a_q; // RULE6
  // route set: fall delay cascades after rise delay onto output A
  assign fall_if.din = db_q[`PCD_DB_ROUTE] ? rise_if.dout :
                       (db_q[`PCD_DB_SRC_FALL] ? aq_b_q : aq_a_q); // RULE6 RULE7

  pcd_edge_delay #(.DW(DW), .FALL(1'b0)) u_rise (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .port(rise_if.dly)
  );

  pcd_edge_delay #(.DW(DW), .FALL(1'b1)) u_fall (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .port(fall_if.dly)
  );

  assign rise_pol = rise_if.dout ^ db_q[`PCD_DB_POL_RISE]; // RULE8
  assign fall_pol = fall_if.dout ^ db_q[`PCD_DB_POL_FALL]; // RULE8 RULE12
  assign dly_a = db_q[`PCD_DB_ROUTE] ? fall_pol : rise_pol; // RULE7 RULE12
  assign dly_b = db_q[`PCD_DB_ROUTE] ? aq_b_q : fall_pol; // RULE7 RULE12
  assign pre_a = db_q[`PCD_DB_BYP_A] ? dly_a : aq_a_q; // RULE9
  assign pre_b = db_q[`PCD_DB_BYP_B] ? dly_b : aq_b_q; // RULE9
  assign fin_a = db_q[`PCD_DB_SWAP_A] ? pre_b : pre_a; // RULE10
  assign fin_b = db_q[`PCD_DB_SWAP_B] ? pre_a : pre_b; // RULE10

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_a_q <= 1'b0; // RULE18
      out_b_q <= 1'b0;
    end else begin
      out_a_q <= fin_a;
      out_b_q <= fin_b;
    end
  end
  assign output_a_o = out_a_q;
  assign output_b_o = out_b_q;

  sequence s_sync_seen;
    sync_input_pulse_i && phase_en ##1 (phase_en && $stable(phase_value_q));
  endsequence

  property p_sync_load;
    @(posedge mclk_i) disable iff (!rstn_i)
    s_sync_seen |=> (time_base_counter_q == $past(phase_value_q));
  endproperty
  a_sync_load: assert property (p_sync_load) else $error("phase not loaded after sync"); // RULE13 RULE14

  property p_sync_out;
    @(posedge mclk_i) disable iff (!rstn_i)
    (tick && run && !load && ctrl_q[`PCD_CTRL_SYNC_EN] && time_base_counter_q == '0)
      |=> sync_output_pulse_o;
  endproperty
  a_sync_out: assert property (p_sync_out) else $error("no sync out at zero"); // RULE15

  property p_turn_down;
    @(posedge mclk_i) disable iff (!rstn_i)
    (ev && dir_q == pcd_pkg::PCD_DIR_UP && time_base_counter_q >= period_value_q)
      |=> dir_q == pcd_pkg::PCD_DIR_DOWN;
  endproperty
  a_turn_down: assert property (p_turn_down) else $error("counter did not turn at period"); // RULE4

  property p_up_set;
    @(posedge mclk_i) disable iff (!rstn_i)
    (ev_cau && !ev_cad && act_a_q.cau == pcd_pkg::PCD_ACT_SET) |=> aq_a_q;
  endproperty
  a_up_set: assert property (p_up_set) else $error("up match did not set A"); // RULE3

  property p_down_clear;
    @(posedge mclk_i) disable iff (!rstn_i)
    (ev_cbd && act_b_q.cbd == pcd_pkg::PCD_ACT_CLR) |=> !aq_b_q;
  endproperty
  a_down_clear: assert property (p_down_clear) else $error("down match did not clear B"); // RULE2

  property p_toggle;
    @(posedge mclk_i) disable iff (!rstn_i)
    (ev_cad && act_a_q.cad == pcd_pkg::PCD_ACT_TGL) |=> aq_a_q != $past(aq_a_q);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle action missed"); // RULE2

  property p_bypass;
    @(posedge mclk_i) disable iff (!rstn_i)
    (!db_q[`PCD_DB_BYP_A] && !db_q[`PCD_DB_SWAP_A]) |=> output_a_o == $past(aq_a_q);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypassed A not undelayed"); // RULE9

  property p_swap;
    @(posedge mclk_i) disable iff (!rstn_i)
    (db_q[`PCD_DB_SWAP_A] && !db_q[`PCD_DB_BYP_B]) |=> output_a_o == $past(aq_b_q);
  endproperty
  a_swap: assert property (p_swap) else $error("swap did not exchange outputs"); // RULE10

  property p_no_event_idle;
    @(posedge mclk_i) disable iff (!rstn_i)
    (!run && !load) |=> $stable(time_base_counter_q) && $stable(aq_a_q) && $stable(aq_b_q);
  endproperty
  a_no_event_idle: assert property (p_no_event_idle) else $error("activity while stopped"); // RULE1
endmodule : pcd_pwm_pair

//--- pcd_pwm_pair_test.sv
module pcd_pwm_pair_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [5:0] adr = 6'h00;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic wq;
  logic sync_in = 1'b0;
  logic sync_out, out_a, out_b;
  logic [15:0] a_high, a_per, b_high, s_per, a_cyc, ovl;
  int error_cnt = 0;
  int n_compared = 0;
  // ctrl, act a, db ctrl, rise, fall, a high, a period, b high, sync period
  localparam logic [15:0] TAB [8][9] = '{
    '{16'h0005, 16'h0060, 16'h0000, 16'h0, 16'h0, 16'd12, 16'd20, 16'd8, 16'd20},
    '{16'h0005, 16'h0006, 16'h0000, 16'h0, 16'h0, 16'd10, 16'd20, 16'd8, 16'd20},
    '{16'h0005, 16'h0003, 16'h0000, 16'h0, 16'h0, 16'd20, 16'd40, 16'd8, 16'd20},
    '{16'h0115, 16'h0060, 16'h0000, 16'h0, 16'h0, 16'd48, 16'd80, 16'd32, 16'd80},
    '{16'h0005, 16'h0060, 16'h00C0, 16'h0, 16'h0, 16'd8, 16'd20, 16'd12, 16'd20},
    '{16'h0005, 16'h0060, 16'h000B, 16'h3, 16'h2, 16'd9, 16'd20, 16'd6, 16'd20},
    '{16'h0005, 16'h0060, 16'h0103, 16'h3, 16'h2, 16'd11, 16'd20, 16'd8, 16'd20},
    '{16'h0005, 16'h00C0, 16'h0000, 16'h0, 16'h0, 16'd20, 16'd40, 16'd8, 16'd20}};
  always #10 mclk_i = ~mclk_i;
  pcd_pwm_pair dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .avs_address_i(adr),
    .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdat),
    .avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(wq),
    .sync_input_pulse_i(sync_in), .sync_output_pulse_o(sync_out),
    .output_a_o(out_a), .output_b_o(out_b));
  pcd_gate_model gate (.mclk_i(mclk_i), .rstn_i(rstn_i), .a_i(out_a), .b_i(out_b),
    .sync_i(sync_out), .a_high_o(a_high), .a_per_o(a_per), .b_high_o(b_high),
    .sync_per_o(s_per), .a_cyc_o(a_cyc), .ovl_o(ovl));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("compared=%0d errors=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
    output logic [31:0] r);
    int n;
    n = 0;
    @(posedge mclk_i);
    adr <= a;
    wdat <= d;
    wr_en <= w;
    rd_en <= !w;
    @(posedge mclk_i);
    while (wq !== 1'b0 && n < 50) begin
      @(posedge mclk_i);
      n++;
    end
    r = rdat;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    if (n >= 50) begin
      chk(32'h0, 32'h1);
      end_sim();
    end
  endtask : bus
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h00000000, r);
  endtask : rd
  task automatic settle;
    logic [15:0] c0;
    int n;
    c0 = a_cyc;
    n = 0;
    while (16'(a_cyc - c0) < 16'h0004 && n < 1000) begin
      @(posedge mclk_i);
      n++;
    end
    if (n >= 1000) begin
      chk(32'h0, 32'h1);
      end_sim();
    end
  endtask : settle
  task automatic t_reset_regs;
    logic [31:0] r;
    chk({29'h0, out_a, out_b, sync_out}, 32'h0);
    wr(6'h28, 32'h0000FFFF);
    rd(6'h28, r);
    chk(r, 32'h0);
    wr(6'h04, 32'h0000000A);
    rd(6'h04, r);
    chk(r, 32'h0000000A);
    wr(6'h3C, 32'h12345678);
    rd(6'h3C, r);
    chk(r, 32'h0);
  endtask : t_reset_regs
  task automatic t_shapes;
    logic [15:0] o0;
    wr(6'h08, 32'h4);
    wr(6'h0C, 32'h6);
    wr(6'h18, 32'h600);
    for (int i = 0; i < 8; i++) begin
      wr(6'h20, {16'h0, TAB[i][3]});
      wr(6'h24, {16'h0, TAB[i][4]});
      wr(6'h1C, {16'h0, TAB[i][2]});
      wr(6'h14, {16'h0, TAB[i][1]});
      wr(6'h00, {16'h0, TAB[i][0]});
      settle();
      o0 = ovl;
      settle();
      chk({16'h0, a_high}, {16'h0, TAB[i][5]});
      chk({16'h0, a_per}, {16'h0, TAB[i][6]});
      chk({16'h0, b_high}, {16'h0, TAB[i][7]});
      chk({16'h0, s_per}, {16'h0, TAB[i][8]});
      if (i == 5) chk({16'h0, 16'(ovl - o0)}, 32'h0);
    end
  endtask : t_shapes
  task automatic t_sync;
    logic [31:0] r;
    wr(6'h10, 32'h5);
    wr(6'h00, 32'h7);
    settle();
    @(posedge mclk_i);
    sync_in <= 1'b1;
    @(posedge mclk_i);
    sync_in <= 1'b0;
    rd(6'h28, r);
    chk({16'h0, r[15:0]}, 32'h5);
  endtask : t_sync
  initial begin
    #(20 * 20000);
    error_cnt++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge mclk_i);
    rstn_i <= 1'b1;
    t_reset_regs();
    t_shapes();
    t_sync();
    end_sim();
  end
endmodule : pcd_pwm_pair_test
